// ==== logic/pcs_pkg.sv ====
// Package with register layout, bus command codes, timing counts and state types.
package pcs_pkg;

   // Command/status dword location in configuration space.
   localparam logic [7:0] CMD_REG_OFF = 8'h04;

   // Command register fields.
   localparam int CMD_BME_BIT = 2;
   localparam int CMD_PERR_BIT = 6;
   localparam int CMD_SERR_BIT = 8;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] CMD_WMASK = 16'h0144;

   // Status register fields, write one to clear.
   localparam int STAT_DPR_BIT = 8;
   localparam int STAT_RMA_BIT = 13;
   localparam int STAT_SSE_BIT = 14;
   localparam int STAT_DPE_BIT = 15;
   localparam logic [15:0] STAT_RESET = 16'h0000;

   // Bus command encodings and configuration type.
   localparam logic [3:0] BUS_MEM_RD = 4'h6;
   localparam logic [3:0] BUS_MEM_WR = 4'h7;
   localparam logic [3:0] BUS_CFG_RD = 4'hA;
   localparam logic [3:0] BUS_CFG_WR = 4'hB;
   localparam logic [1:0] CFG_TYPE0 = 2'h0;

   // Clocks without a device select before the initiator gives up.
   localparam int MABORT_CLKS = 5;
   localparam logic [2:0] MABORT_LAST = 3'(MABORT_CLKS - 1);
   // Clocks after an initiator write in which a target error report counts.
   localparam logic [1:0] MPERR_WIN = 2'h3;

   typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} pcs_mst_type;
   typedef enum logic [2:0] {T_IDLE, T_WAIT, T_DATA, T_HOLD, T_TURN} pcs_tgt_type;

endpackage : pcs_pkg

// ==== logic/pcs_parity.sv ====
// Even parity over the 32 address/data and 4 command lines, registered one clock late.
module pcs_parity import pcs_pkg::*; (
   input wire logic clk, // Bus clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic ce, // Clock enable.
   input wire logic [31:0] ad, // Address/data lines as seen on the bus.
   input wire logic [3:0] cbe, // Command/byte-enable lines as seen on the bus.
   output logic par // Parity of the previous clock's lines.
);

   typedef struct packed {
      logic par;
   } pcs_par_type;

   pcs_par_type st_r;
   pcs_par_type st_nxt;

   // The parity bit makes the 37 lines even, so it is the plain XOR of the 36.
   always_comb begin
      st_nxt = st_r;
      st_nxt.par = ^{ad, cbe};
   end

   // Freezes with the clock enable like all other state.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign par = st_r.par;

endmodule : pcs_parity

// ==== logic/pcs_bus_ctrl.sv ====
// Bus control signalling: configuration target, single-phase initiator and parity/error logic.
module pcs_bus_ctrl import pcs_pkg::*; (
   input wire logic clk, // Bus clock, 100 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire logic [31:0] ad_pin, // Address/data lines sampled.
   output logic [31:0] ad_drv, // Address/data value driven.
   output logic ad_en, // Address/data output enable.
   input wire logic [3:0] cbe_pin, // Command/byte enables sampled, active low enables.
   output logic [3:0] cbe_drv, // Command/byte enables driven.
   output logic cbe_en, // Command/byte enable output enable.
   input wire logic par_pin, // Parity line sampled.
   output logic par_drv, // Parity value driven.
   output logic par_en, // Parity output enable.
   input wire logic frame_n_pin, // Frame sampled.
   output logic frame_n_drv, // Frame driven.
   output logic frame_n_en, // Frame output enable.
   input wire logic irdy_n_pin, // Initiator ready sampled.
   output logic irdy_n_drv, // Initiator ready driven.
   output logic irdy_n_en, // Initiator ready output enable.
   input wire logic trdy_n_pin, // Target ready sampled.
   output logic trdy_n_drv, // Target ready driven.
   output logic trdy_n_en, // Target ready output enable.
   input wire logic stop_n_pin, // Stop sampled.
   output logic stop_n_drv, // Stop driven.
   output logic stop_n_en, // Stop output enable.
   input wire logic devsel_n_pin, // Device select sampled.
   output logic devsel_n_drv, // Device select driven.
   output logic devsel_n_en, // Device select output enable.
   input wire logic perr_n_pin, // Parity error sampled.
   output logic perr_n_drv, // Parity error driven.
   output logic perr_n_en, // Parity error output enable.
   output logic serr_n_drv, // System error driven, open drain.
   output logic serr_n_en, // System error enable, one-clock pulse.
   output logic req_n_drv, // Bus request, active low.
   input wire logic gnt_n_pin, // Bus grant, active low.
   input wire logic idsel_pin, // Configuration select.
   input wire logic cb_addr_perr, // Side-bus address parity error pulse.
   input wire logic mst_start, // Start one initiator transfer.
   input wire logic mst_write, // Transfer is a write.
   input wire logic [31:0] mst_addr, // Transfer address.
   input wire logic [31:0] mst_wdata, // Write data.
   input wire logic [3:0] mst_be_n, // Byte enables, active low.
   output logic mst_busy, // Transfer pending or running.
   output logic mst_done, // Data phase completed, pulse.
   output logic mst_stopped, // Target stopped without data, pulse.
   output logic mst_abort, // Master abort, pulse.
   output logic [31:0] mst_rdata // Read data of the last read.
);

   typedef struct packed {
      pcs_mst_type mstate;
      pcs_tgt_type tstate;
      logic [15:0] cmd;
      logic [15:0] stat;
      logic pend;
      logic mwrite;
      logic [31:0] maddr;
      logic [31:0] mwdata;
      logic [3:0] mbe_n;
      logic [31:0] rdata;
      logic [2:0] cnt;
      logic busy;
      logic done;
      logic stopped;
      logic abort;
      logic twrite;
      logic thit;
      logic frame_q;
      logic addr_chk;
      logic data_chk;
      logic mchk;
      logic [1:0] mperr_win;
      logic [31:0] ad_drv;
      logic ad_en;
      logic [3:0] cbe_drv;
      logic cbe_en;
      logic par_en;
      logic frame_n_drv;
      logic frame_n_en;
      logic irdy_n_drv;
      logic irdy_n_en;
      logic trdy_n_drv;
      logic trdy_n_en;
      logic stop_n_drv;
      logic stop_n_en;
      logic devsel_n_drv;
      logic devsel_n_en;
      logic perr_n_drv;
      logic perr_n_en;
      logic serr_n_drv;
      logic serr_n_en;
      logic req_n_drv;
   } pcs_state_type;

   localparam pcs_state_type ST_RESET = '{mstate: M_IDLE, tstate: T_IDLE, cmd: CMD_RESET,
      stat: STAT_RESET, frame_q: 1'b1, frame_n_drv: 1'b1, irdy_n_drv: 1'b1, trdy_n_drv: 1'b1,
      stop_n_drv: 1'b1, devsel_n_drv: 1'b1, perr_n_drv: 1'b1, serr_n_drv: 1'b1,
      req_n_drv: 1'b1, default: '0};

   pcs_state_type st_r;
   pcs_state_type st_nxt;
   logic par_calc;
   logic addr_ph;
   logic mism;

   // Bus lines run on this same clock, so they are read directly with no synchroniser.
   pcs_parity u_par (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .ad(ad_pin),
      .cbe(cbe_pin),
      .par(par_calc)
   );

   // An address phase is the first clock of FRAME asserted.
   assign addr_ph = !frame_n_pin && st_r.frame_q;
   assign mism = par_calc ^ par_pin;

   // Next-state logic for both bus roles and the error reporting.
   always_comb begin
      st_nxt = st_r;
      st_nxt.frame_q = frame_n_pin;
      st_nxt.done = 1'b0;
      st_nxt.stopped = 1'b0;
      st_nxt.abort = 1'b0;
      st_nxt.addr_chk = addr_ph;
      st_nxt.data_chk = 1'b0;
      st_nxt.mchk = 1'b0;
      st_nxt.serr_n_en = 1'b0;
      st_nxt.serr_n_drv = 1'b1;
      st_nxt.par_en = st_r.ad_en;
      // Parity error is driven low one clock, high one clock, then released.
      if (st_r.perr_n_en && !st_r.perr_n_drv) begin
         st_nxt.perr_n_drv = 1'b1;
      end else begin
         st_nxt.perr_n_en = 1'b0;
      end
      if (st_r.mperr_win != 2'h0) begin
         st_nxt.mperr_win = st_r.mperr_win - 2'h1;
      end
      // Requests while busy or with bus mastering off are ignored.
      if (mst_start && !st_r.pend && st_r.cmd[CMD_BME_BIT]) begin
         st_nxt.pend = 1'b1;
         st_nxt.mwrite = mst_write;
         st_nxt.maddr = mst_addr;
         st_nxt.mwdata = mst_wdata;
         st_nxt.mbe_n = mst_be_n;
      end
      // Initiator: address phase, one data phase, turnaround.
      case (st_r.mstate)
         M_IDLE: begin
            if (st_r.pend && !gnt_n_pin && frame_n_pin && irdy_n_pin
                && st_r.tstate == T_IDLE) begin
               st_nxt.mstate = M_ADDR;
               st_nxt.frame_n_drv = 1'b0;
               st_nxt.frame_n_en = 1'b1;
               st_nxt.ad_drv = st_r.maddr;
               st_nxt.ad_en = 1'b1;
               st_nxt.cbe_drv = st_r.mwrite ? BUS_MEM_WR : BUS_MEM_RD;
               st_nxt.cbe_en = 1'b1;
            end
         end
         M_ADDR: begin
            st_nxt.mstate = M_DATA;
            st_nxt.frame_n_drv = 1'b1;
            st_nxt.irdy_n_drv = 1'b0;
            st_nxt.irdy_n_en = 1'b1;
            st_nxt.cbe_drv = st_r.mbe_n;
            st_nxt.ad_drv = st_r.mwdata;
            st_nxt.ad_en = st_r.mwrite;
            st_nxt.cnt = '0;
         end
         M_DATA: begin
            if (!trdy_n_pin || !stop_n_pin || (devsel_n_pin && st_r.cnt == MABORT_LAST)) begin
               st_nxt.mstate = M_TURN;
               st_nxt.irdy_n_drv = 1'b1;
               st_nxt.frame_n_en = 1'b0;
               st_nxt.ad_en = 1'b0;
               st_nxt.cbe_en = 1'b0;
               st_nxt.pend = 1'b0;
            end
            if (!trdy_n_pin) begin
               st_nxt.done = 1'b1;
               if (st_r.mwrite) begin
                  st_nxt.mperr_win = MPERR_WIN;
               end else begin
                  st_nxt.rdata = ad_pin;
                  st_nxt.data_chk = 1'b1;
                  st_nxt.mchk = 1'b1;
               end
            end else if (!stop_n_pin) begin
               st_nxt.stopped = 1'b1;
            end else if (devsel_n_pin && st_r.cnt == MABORT_LAST) begin
               st_nxt.abort = 1'b1;
            end else if (st_r.cnt != MABORT_LAST) begin
               st_nxt.cnt = st_r.cnt + 3'h1;
            end
         end
         M_TURN: begin
            st_nxt.irdy_n_en = 1'b0;
            st_nxt.mstate = M_IDLE;
         end
         default: st_nxt.mstate = M_IDLE;
      endcase
      st_nxt.busy = st_nxt.pend;
      st_nxt.req_n_drv = !(st_nxt.pend && st_nxt.mstate == M_IDLE);
      // Target: claims type 0 configuration cycles selected by the select input.
      case (st_r.tstate)
         T_IDLE: begin
            if (addr_ph && idsel_pin && ad_pin[1:0] == CFG_TYPE0
                && (cbe_pin == BUS_CFG_RD || cbe_pin == BUS_CFG_WR)) begin
               st_nxt.tstate = T_WAIT;
               st_nxt.devsel_n_drv = 1'b0;
               st_nxt.devsel_n_en = 1'b1;
               st_nxt.trdy_n_drv = 1'b1;
               st_nxt.trdy_n_en = 1'b1;
               st_nxt.stop_n_drv = 1'b1;
               st_nxt.stop_n_en = 1'b1;
               st_nxt.twrite = cbe_pin == BUS_CFG_WR;
               st_nxt.thit = ad_pin[7:0] == CMD_REG_OFF;
            end
         end
         T_WAIT: begin
            // The wait clock doubles as the address/data turnaround on reads.
            st_nxt.tstate = T_DATA;
            st_nxt.trdy_n_drv = 1'b0;
            st_nxt.stop_n_drv = frame_n_pin;
            if (!st_r.twrite) begin
               st_nxt.ad_drv = st_r.thit ? {st_r.stat, st_r.cmd} : '0;
               st_nxt.ad_en = 1'b1;
            end
         end
         T_DATA: begin
            if (!irdy_n_pin) begin
               if (st_r.twrite) begin
                  st_nxt.data_chk = 1'b1;
                  if (st_r.thit) begin
                     for (int i = 0; i < 16; i++) begin
                        if (!cbe_pin[i / 8] && CMD_WMASK[i]) begin
                           st_nxt.cmd[i] = ad_pin[i];
                        end
                        if (!cbe_pin[2 + i / 8] && ad_pin[16 + i]) begin
                           st_nxt.stat[i] = 1'b0;
                        end
                     end
                  end
               end
               st_nxt.ad_en = 1'b0;
               st_nxt.trdy_n_drv = 1'b1;
               if (!frame_n_pin) begin
                  // Burst attempt: hold STOP until the initiator drops FRAME.
                  st_nxt.tstate = T_HOLD;
                  st_nxt.stop_n_drv = 1'b0;
               end else begin
                  st_nxt.tstate = T_TURN;
                  st_nxt.devsel_n_drv = 1'b1;
                  st_nxt.stop_n_drv = 1'b1;
               end
            end
         end
         T_HOLD: begin
            if (frame_n_pin) begin
               st_nxt.tstate = T_TURN;
               st_nxt.devsel_n_drv = 1'b1;
               st_nxt.stop_n_drv = 1'b1;
            end
         end
         T_TURN: begin
            st_nxt.tstate = T_IDLE;
            st_nxt.devsel_n_en = 1'b0;
            st_nxt.trdy_n_en = 1'b0;
            st_nxt.stop_n_en = 1'b0;
         end
         default: st_nxt.tstate = T_IDLE;
      endcase
      // Error sets come after the register write so that a set wins over a clear.
      if (st_nxt.abort) begin
         st_nxt.stat[STAT_RMA_BIT] = 1'b1;
      end
      if ((st_r.addr_chk && mism) || (st_r.data_chk && mism)) begin
         st_nxt.stat[STAT_DPE_BIT] = 1'b1;
      end
      if ((st_r.addr_chk && mism) || cb_addr_perr) begin
         if (st_r.cmd[CMD_SERR_BIT]) begin
            st_nxt.serr_n_en = 1'b1;
            st_nxt.serr_n_drv = 1'b0;
            st_nxt.stat[STAT_SSE_BIT] = 1'b1;
         end
      end
      if (st_r.data_chk && mism && st_r.cmd[CMD_PERR_BIT]) begin
         st_nxt.perr_n_drv = 1'b0;
         st_nxt.perr_n_en = 1'b1;
         if (st_r.mchk) begin
            st_nxt.stat[STAT_DPR_BIT] = 1'b1;
         end
      end
      if (st_r.mperr_win != 2'h0 && !perr_n_pin && st_r.cmd[CMD_PERR_BIT]) begin
         st_nxt.stat[STAT_DPR_BIT] = 1'b1;
      end
   end

   // State register; the clock enable holds everything still.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_RESET;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // Every output is a register bit.
   assign ad_drv = st_r.ad_drv;
   assign ad_en = st_r.ad_en;
   assign cbe_drv = st_r.cbe_drv;
   assign cbe_en = st_r.cbe_en;
   assign par_drv = par_calc;
   assign par_en = st_r.par_en;
   assign frame_n_drv = st_r.frame_n_drv;
   assign frame_n_en = st_r.frame_n_en;
   assign irdy_n_drv = st_r.irdy_n_drv;
   assign irdy_n_en = st_r.irdy_n_en;
   assign trdy_n_drv = st_r.trdy_n_drv;
   assign trdy_n_en = st_r.trdy_n_en;
   assign stop_n_drv = st_r.stop_n_drv;
   assign stop_n_en = st_r.stop_n_en;
   assign devsel_n_drv = st_r.devsel_n_drv;
   assign devsel_n_en = st_r.devsel_n_en;
   assign perr_n_drv = st_r.perr_n_drv;
   assign perr_n_en = st_r.perr_n_en;
   assign serr_n_drv = st_r.serr_n_drv;
   assign serr_n_en = st_r.serr_n_en;
   assign req_n_drv = st_r.req_n_drv;
   assign mst_busy = st_r.busy;
   assign mst_done = st_r.done;
   assign mst_stopped = st_r.stopped;
   assign mst_abort = st_r.abort;
   assign mst_rdata = st_r.rdata;

   // Checks of the bus behaviour against its causes.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_claim;
      (ce && st_r.tstate == T_IDLE && addr_ph && idsel_pin && ad_pin[1:0] == CFG_TYPE0
       && cbe_pin == BUS_CFG_RD) |=> (!devsel_n_drv && devsel_n_en) ##1 !devsel_n_drv;
   endproperty
   a_claim: assert property (p_claim) else $error("config cycle not claimed");

   property p_noclaim;
      (ce && st_r.tstate == T_IDLE && addr_ph && !idsel_pin) |=> devsel_n_drv;
   endproperty
   a_noclaim: assert property (p_noclaim) else $error("claimed without select");

   property p_abort;
      (ce && st_r.mstate == M_DATA && devsel_n_pin && trdy_n_pin && stop_n_pin
       && st_r.cnt == MABORT_LAST) |=> mst_abort && st_r.mstate == M_TURN;
   endproperty
   a_abort: assert property (p_abort) else $error("master abort missing");

   property p_frame;
      st_r.mstate == M_ADDR |-> !frame_n_drv && frame_n_en ##1 (frame_n_drv || $past(!ce));
   endproperty
   a_frame: assert property (p_frame) else $error("frame sequence wrong");

   property p_done;
      mst_done |-> $past(!trdy_n_pin && !irdy_n_drv && irdy_n_en);
   endproperty
   a_done: assert property (p_done) else $error("done without both ready");

   property p_trdy;
      st_r.tstate == T_DATA |-> !trdy_n_drv && trdy_n_en && !devsel_n_drv;
   endproperty
   a_trdy: assert property (p_trdy) else $error("target ready not driven");

   property p_perr;
      (perr_n_en && !perr_n_drv) |-> $past(st_r.cmd[CMD_PERR_BIT] && mism);
   endproperty
   a_perr: assert property (p_perr) else $error("parity error without enable");

   property p_serr;
      (serr_n_en && !serr_n_drv) |-> $past(st_r.cmd[CMD_SERR_BIT]);
   endproperty
   a_serr: assert property (p_serr) else $error("system error without enable");

   property p_cbserr;
      (ce && cb_addr_perr && st_r.cmd[CMD_SERR_BIT]) |=> serr_n_en && !serr_n_drv;
   endproperty
   a_cbserr: assert property (p_cbserr) else $error("side error not signalled");

   property p_req;
      (st_r.pend && st_r.mstate == M_IDLE) |-> !req_n_drv;
   endproperty
   a_req: assert property (p_req) else $error("request not asserted");

   property p_stop;
      (ce && st_r.mstate == M_DATA && !stop_n_pin && trdy_n_pin) |=> mst_stopped ##1 !irdy_n_en;
   endproperty
   a_stop: assert property (p_stop) else $error("initiator ignored stop");

   property p_par;
      par_en |-> par_drv == $past(^{ad_pin, cbe_pin}) || $past(!ce);
   endproperty
   a_par: assert property (p_par) else $error("parity wrong");

   property p_start;
      (st_r.mstate == M_ADDR && $past(st_r.mstate) == M_IDLE)
         |-> $past(!gnt_n_pin && frame_n_pin && irdy_n_pin);
   endproperty
   a_start: assert property (p_start) else $error("start without idle grant");

   c_read: cover property (mst_done && !st_r.mwrite);
   c_abort: cover property (mst_abort);
   c_cfgwr: cover property (st_r.tstate == T_DATA && st_r.twrite && !irdy_n_pin);
   c_perr: cover property (perr_n_en && !perr_n_drv);

endmodule : pcs_bus_ctrl

// ==== testbench/pcs_bus_agent.sv ====
// Far side of the bus: an arbiter and one memory target with a chosen response.
module pcs_bus_agent import pcs_pkg::*; (
   input wire logic clk, // Bus clock.
   input wire logic rst, // Reset, active high.
   input wire logic [1:0] mode, // 0 prompt, 1 slow, 2 silent, 3 disconnect.
   input wire logic req_n, // Request from the block.
   output logic gnt_n, // Grant to the block.
   input wire logic mine, // Block drives the frame line.
   input wire logic frame_n, // Resolved frame line.
   input wire logic irdy_n, // Resolved initiator ready line.
   input wire logic [31:0] ad, // Resolved address/data lines.
   input wire logic [3:0] cbe, // Resolved command lines.
   output logic dev_n, // Device select driven.
   output logic trdy_n, // Target ready driven.
   output logic stop_n, // Stop driven.
   output logic ad_en, // Read data driven.
   output logic [31:0] ad_o, // Read data, the inverted address.
   output logic [31:0] wd // Data of the last completed data phase, read or write.
);
   logic wr;
   logic act;
   logic [3:0] cnt;
   // Claim after a chosen delay; release once frame and ready are both high again.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {gnt_n, dev_n, trdy_n, stop_n} <= 4'hF;
         {act, wr, ad_en, cnt, ad_o, wd} <= '0;
      end else begin
         gnt_n <= req_n;
         if (!act && mine && !frame_n) begin
            act <= 1'b1;
            cnt <= 4'h0;
            wr <= (cbe == BUS_MEM_WR);
            ad_o <= ~ad;
         end else if (act) begin
            cnt <= cnt + 4'h1;
            if (mode != 2'h2 && cnt == (mode == 2'h1 ? 4'h2 : 4'h0)) begin
               dev_n <= 1'b0;
               trdy_n <= (mode == 2'h3);
               stop_n <= (mode != 2'h3);
               ad_en <= !wr;
            end
            if (!irdy_n && !trdy_n) wd <= ad;
            if (frame_n && irdy_n && cnt > 4'h1) begin
               {act, ad_en} <= 2'h0;
               {dev_n, trdy_n, stop_n} <= 3'h7;
            end
         end
      end
   end
endmodule : pcs_bus_agent

// ==== testbench/pcs_bus_ctrl_tb.sv ====
// Self-checking bench for the bus control block against a register and transfer model.
module pcs_bus_ctrl_tb import pcs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, ce = 1, idsel_pin = 0, cb_addr_perr = 0, mst_start = 0;
   logic mst_write = 0, tb_frame = 1, tb_irdy = 1, flip = 0, pexp = 0, hit, gnt_n_pin;
   logic ad_en, cbe_en, par_drv, par_en, frame_n_drv, frame_n_en, irdy_n_drv, irdy_n_en;
   logic trdy_n_drv, trdy_n_en, stop_n_drv, stop_n_en, devsel_n_drv, devsel_n_en, perr_n_drv;
   logic perr_n_en, serr_n_drv, serr_n_en, req_n_drv, mst_busy, mst_done, mst_stopped;
   logic mst_abort, a_en, a_trdy, a_stop, a_dev;
   logic [1:0] mode = 0;
   logic [3:0] cbe_drv, tb_cbe = 4'hF, mst_be_n = 4'h0;
   logic [15:0] exp_cmd = 0, exp_stat = 0;
   logic [31:0] ad_drv, mst_addr = 0, mst_wdata = 0, mst_rdata, tb_ad = 0, a_ad, ag_wd, q, d;
   int errors = 0, checked = 0, seed = 32'h0ED56555, perr_cnt = 0, serr_cnt = 0;
   // Each line resolves to its driver, else its pull-up or the bench's own value.
   wire [31:0] ad_pin = ad_en ? ad_drv : a_en ? a_ad : tb_ad;
   wire [3:0] cbe_pin = cbe_en ? cbe_drv : tb_cbe;
   wire par_pin = par_en ? par_drv : pexp ^ flip;
   wire frame_n_pin = frame_n_en ? frame_n_drv : tb_frame;
   wire irdy_n_pin = irdy_n_en ? irdy_n_drv : tb_irdy;
   wire trdy_n_pin = trdy_n_en ? trdy_n_drv : a_trdy;
   wire stop_n_pin = stop_n_en ? stop_n_drv : a_stop;
   wire devsel_n_pin = devsel_n_en ? devsel_n_drv : a_dev;
   wire perr_n_pin = perr_n_en ? perr_n_drv : 1'b1;
   pcs_bus_ctrl dut_u (.*);
   pcs_bus_agent agent_u (.clk(clk), .rst(rst), .mode(mode), .req_n(req_n_drv),
      .gnt_n(gnt_n_pin), .mine(frame_n_en), .frame_n(frame_n_pin), .irdy_n(irdy_n_pin),
      .ad(ad_pin), .cbe(cbe_pin), .dev_n(a_dev), .trdy_n(a_trdy), .stop_n(a_stop),
      .ad_en(a_en), .ad_o(a_ad), .wd(ag_wd));
   always #5 clk = ~clk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   // Parity of the lines one clock late, and counts of error pulses the block drives.
   always @(posedge clk) begin
      pexp <= ^{ad_pin, cbe_pin};
      if (perr_n_en === 1'b1 && perr_n_drv === 1'b0) perr_cnt++;
      if (serr_n_en === 1'b1 && serr_n_drv === 1'b0) serr_cnt++;
      if (par_en === 1'b1) chk("par", pexp, par_drv);
   end
   // One configuration access to the command dword; reads are compared with the model.
   task automatic cfg(input logic w, input logic s, input logic [31:0] v, input logic b = 1'b0);
      int k;
      @(posedge clk) tb_frame <= 1'b0;
      idsel_pin <= s;
      tb_cbe <= w ? BUS_CFG_WR : BUS_CFG_RD;
      tb_ad <= {24'h0, CMD_REG_OFF};
      @(posedge clk) tb_frame <= !b;
      {tb_irdy, idsel_pin, tb_cbe, tb_ad} <= {2'h0, 4'h0, v};
      hit = 0;
      for (k = 0; k < 8; k++) begin
         @(posedge clk);
         if (devsel_n_pin === 1'b0) hit = 1;
         if (trdy_n_pin === 1'b0) break;
      end
      q = ad_pin;
      // A burst attempt must see STOP together with the one data phase.
      if (s) chk("stop", !b, stop_n_pin);
      tb_frame <= 1'b1;
      tb_irdy <= 1'b1;
      tb_ad <= ~v;
      chk("claim", s, hit);
      if (w && s) {exp_stat, exp_cmd} = {exp_stat & ~v[31:16], v[15:0] & CMD_WMASK};
      if (!w && s) chk("reg", {exp_stat, exp_cmd}, q);
      @(posedge clk);
   endtask : cfg
   // One initiator transfer against the target answering in the given mode.
   task automatic mst(input logic [1:0] m, input logic w);
      int k;
      {mst_addr, mst_wdata} <= {$random(seed), $random(seed)};
      @(posedge clk) {mode, mst_start, mst_write} <= {m, 1'b1, w};
      @(posedge clk) mst_start <= 1'b0;
      for (k = 0; k < 40 && {mst_done, mst_stopped, mst_abort} === 3'h0; k++) @(posedge clk);
      if (k == 40) begin
         errors++;
         test_done();
      end
      chk("result", m == 2 ? 3'h1 : m == 3 ? 3'h2 : 3'h4, {mst_done, mst_stopped, mst_abort});
      if (m < 2) chk("data", w ? mst_wdata : ~mst_addr, w ? ag_wd : mst_rdata);
      if (m == 2) exp_stat = exp_stat | 16'h2000;
   endtask : mst
   // A side-bus address parity error; a system error pulse is counted only if enabled.
   task automatic cb_err;
      @(posedge clk) cb_addr_perr <= 1'b1;
      @(posedge clk) cb_addr_perr <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : cb_err
   // Main sequence: reset, register access, transfers, then the error reports.
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      cfg(0, 1, 0);
      cfg(0, 1, 0, 1);
      cfg(0, 0, 0);
      d = $random(seed) & 32'hFFFFFFFB;
      cfg(1, 1, d);
      cfg(0, 1, 0);
      @(posedge clk) mst_start <= 1'b1;
      @(posedge clk) mst_start <= 1'b0;
      repeat (2) @(posedge clk);
      chk("busy", 0, mst_busy);
      cfg(1, 1, 32'h44);
      for (int m = 0; m < 4; m++) for (int w = 0; w < 2; w++) mst(m[1:0], w[0]);
      cfg(0, 1, 0);
      flip <= 1'b1;
      cfg(1, 1, 32'h44);
      flip <= 1'b0;
      exp_stat = exp_stat | 16'h8000;
      repeat (4) @(posedge clk);
      chk("perr", 1, perr_cnt);
      cfg(0, 1, 0);
      cb_err();
      cfg(1, 1, 32'hFFFF0100);
      cfg(0, 1, 0);
      cb_err();
      // Address parity error with the system-error enable set, then a frozen side error.
      flip <= 1'b1;
      cfg(1, 1, 32'h100);
      flip <= 1'b0;
      exp_stat = exp_stat | 16'hC000;
      cfg(0, 1, 0);
      ce <= 1'b0;
      cb_err();
      ce <= 1'b1;
      chk("serr", 2, serr_cnt);
      test_done();
   end
endmodule : pcs_bus_ctrl_tb
